// >>> rtl/supply_mode_fail_config.v
// Operating-mode state machine with strap-latched failure-response configuration.
// Assumes an APB master on pclk; pins from outside are double-synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "supply_mode_map.vh"

module supply_mode_fail_config #(
  parameter [31:0] RESET_DELAY_CYCLES = `RESET_DELAY_CYC,
  parameter [31:0] LONG_WINDOW_CYCLES = `LONG_WINDOW_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        int_pin_in,
  output wire        int_pin_out,
  output wire        int_pin_oe,
  input  wire        test_pin,
  input  wire        wake_event,
  input  wire        overtemp,
  input  wire        core_undervolt,
  input  wire        core_overvolt,
  input  wire        wd_trigger,
  output reg         host_reset_output,
  output reg         fail_outputs,
  output reg         core_supply_enable,
  output reg         core_supply_low_power,
  output reg         watchdog_running,
  output reg         development_mode,
  output reg  [2:0]  operating_mode_bits
);

  localparam [31:0] FILT_CYC_FULL = `FILTER_CYC;
  // Filter count fits four bits; cut on purpose
  localparam [3:0]  FILT_CYC      = FILT_CYC_FULL[3:0];

  // Synchronisers for every pin that enters from the board
  reg [1:0] int_sync_reg;
  reg [1:0] test_sync_reg;
  reg [1:0] wake_sync_reg;
  reg [1:0] ot_sync_reg;
  reg [1:0] uv_sync_reg;
  reg [1:0] ov_sync_reg;
  reg [1:0] wdt_sync_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_sync_reg  <= 2'h0;
      test_sync_reg <= 2'h3;
      wake_sync_reg <= 2'h0;
      ot_sync_reg   <= 2'h0;
      uv_sync_reg   <= 2'h0;
      ov_sync_reg   <= 2'h0;
      wdt_sync_reg  <= 2'h0;
    end else begin
      int_sync_reg  <= {int_sync_reg[0], int_pin_in};
      test_sync_reg <= {test_sync_reg[0], test_pin};
      wake_sync_reg <= {wake_sync_reg[0], wake_event};
      ot_sync_reg   <= {ot_sync_reg[0], overtemp};
      uv_sync_reg   <= {uv_sync_reg[0], core_undervolt};
      ov_sync_reg   <= {ov_sync_reg[0], core_overvolt};
      wdt_sync_reg  <= {wdt_sync_reg[0], wd_trigger};
    end
  end
  wire int_s  = int_sync_reg[1];
  wire wake_s = wake_sync_reg[1];
  wire ot_s   = ot_sync_reg[1];
  wire uv_s   = uv_sync_reg[1];
  wire ov_s   = ov_sync_reg[1];
  reg  wdt_prev_reg;
  wire wdt_pulse = wdt_sync_reg[1] & ~wdt_prev_reg;

  // APB decode
  wire apb_wr = psel & penable & pwrite;
  wire apb_setup_rd = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function addr_is;
    input [11:0] a;
    input [11:0] off;
    begin
      addr_is = (a == off);
    end
  endfunction

  reg  [2:0]  mode_reg;
  reg  [2:0]  mode_next;
  reg  [1:0]  hardware_control_reg;
  reg  [2:0]  flags_reg;
  reg  [15:0] frame_reg;
  reg         pin_strap_config;
  reg         core_overvolt_flag;
  reg         wd_fail_cnt_reg;
  reg  [31:0] timer_reg;
  reg  [31:0] wd_timer_reg;
  reg  [3:0]  filt_cnt_reg;
  reg         filt_val_reg;
  reg         filt_last_reg;
  reg         filt_stable_reg;
  reg         rst_prev_reg;

  wire core_overvolt_reset_enable = hardware_control_reg[`HW_OV_RST_BIT];
  wire soft_cfg = hardware_control_reg[`HW_CFG_BIT];
  // Any frame written while in init counts as a command
  wire frame_wr = apb_wr & addr_is(paddr, `FRAME_OFF);
  wire mode_wr  = apb_wr & addr_is(paddr, `MODE_CTRL_OFF);
  wire soft_rst = mode_wr & (pwdata[2:0] == `CTRL_SOFT_RESET);
  wire wd_active = ~development_mode & ((mode_reg == `MODE_INIT) | (mode_reg == `MODE_NORMAL)
                   | (mode_reg == `MODE_STOP));
  wire wd_fail = wd_active & (wd_timer_reg == 32'h0);
  wire ov_event = ov_s & core_overvolt_reset_enable & ~core_overvolt_flag
                  & (mode_reg != `MODE_RESTART) & (mode_reg != `MODE_FAILSAFE);
  wire wake_ok = wake_s & (mode_reg != `MODE_INIT);
  wire dev_next = development_mode | ((mode_reg == `MODE_INIT) & ~test_sync_reg[1]);

  // Watchdog with long open window; loaded at reset so init cannot fail at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_timer_reg <= LONG_WINDOW_CYCLES;
      wdt_prev_reg <= 1'b0;
    end else begin
      wdt_prev_reg <= wdt_sync_reg[1];
      if (wdt_pulse || !wd_active || mode_next != mode_reg)
        wd_timer_reg <= LONG_WINDOW_CYCLES;
      else if (wd_timer_reg != 32'h0)
        wd_timer_reg <= wd_timer_reg - 32'h1;
    end
  end

  // Mode transitions
  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      `MODE_INIT: begin
        if (frame_wr)
          mode_next = `MODE_NORMAL;
      end
      `MODE_NORMAL, `MODE_STOP, `MODE_SLEEP: begin
        if (mode_wr && pwdata[2:0] <= `MODE_SLEEP && mode_reg != `MODE_SLEEP)
          mode_next = pwdata[2:0];
        if (mode_reg == `MODE_SLEEP && wake_ok)
          mode_next = `MODE_RESTART;
        if (uv_s && mode_reg != `MODE_SLEEP)
          mode_next = `MODE_RESTART;
      end
      `MODE_RESTART: begin
        if (!uv_s && !ov_s && timer_reg >= RESET_DELAY_CYCLES)
          mode_next = `MODE_NORMAL;
      end
      `MODE_FAILSAFE: begin
        if (wake_ok || !ot_s)
          mode_next = `MODE_RESTART;
      end
      default: mode_next = `MODE_INIT;
    endcase
    if (wd_fail) begin
      if (pin_strap_config)
        mode_next = `MODE_RESTART;
      else if (!soft_cfg && !wd_fail_cnt_reg)
        mode_next = `MODE_RESTART;
      else
        mode_next = `MODE_FAILSAFE;
    end
    if (ov_event)
      mode_next = pin_strap_config ? `MODE_RESTART : `MODE_FAILSAFE;
    if (soft_rst)
      mode_next = `MODE_INIT;
  end

  // Reset delay timer and host reset output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg          <= `MODE_INIT;
      timer_reg         <= 32'h0;
      host_reset_output <= 1'b0;
      rst_prev_reg      <= 1'b0;
    end else begin
      mode_reg     <= mode_next;
      rst_prev_reg <= host_reset_output;
      if (mode_next != mode_reg || mode_reg == `MODE_SLEEP || mode_reg == `MODE_FAILSAFE)
        timer_reg <= 32'h0;
      else if (timer_reg < RESET_DELAY_CYCLES)
        timer_reg <= timer_reg + 32'h1;
      case (mode_reg)
        `MODE_RESTART, `MODE_SLEEP, `MODE_FAILSAFE: host_reset_output <= 1'b0;
        `MODE_INIT: host_reset_output <= (timer_reg >= RESET_DELAY_CYCLES) | host_reset_output;
        default: host_reset_output <= 1'b1;
      endcase
    end
  end

  // Pull-down window: reset low while power-on flag stands
  wire sampling = ~host_reset_output & flags_reg[`ST_FLAG_POR];
  assign int_pin_out = 1'b0;
  assign int_pin_oe  = sampling;
  wire   ro_rise = host_reset_output & ~rst_prev_reg;

  // Continuous filter; unstable input leaves zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_cnt_reg     <= 4'h0;
      filt_val_reg     <= 1'b0;
      filt_last_reg    <= 1'b0;
      filt_stable_reg  <= 1'b0;
      pin_strap_config <= 1'b0;
      development_mode <= 1'b0;
    end else begin
      filt_last_reg <= int_s;
      if (!sampling) begin
        filt_cnt_reg    <= 4'h0;
        filt_stable_reg <= 1'b0;
      end else if (int_s != filt_last_reg) begin
        filt_cnt_reg    <= 4'h0;
        filt_stable_reg <= 1'b0;
      end else if (filt_cnt_reg < FILT_CYC) begin
        filt_cnt_reg <= filt_cnt_reg + 4'h1;
      end else begin
        filt_val_reg    <= int_s;
        filt_stable_reg <= 1'b1;
      end
      if (ro_rise && flags_reg[`ST_FLAG_POR])
        pin_strap_config <= filt_stable_reg & filt_val_reg;
      development_mode <= dev_next;
    end
  end

  // Failure counting, flags, fail outputs, registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hardware_control_reg <= `HARDWARE_CONTROL_REG_RESET;
      flags_reg            <= 3'h1;
      core_overvolt_flag   <= 1'b0;
      wd_fail_cnt_reg      <= 1'b0;
      fail_outputs         <= 1'b0;
      frame_reg            <= 16'h0;
    end else begin
      if (apb_wr && addr_is(paddr, `HARDWARE_CONTROL_REG_OFF))
        hardware_control_reg <= pwdata[1:0];
      if (frame_wr)
        frame_reg <= pwdata[15:0];
      if (apb_wr && addr_is(paddr, `STATUS_OFF))
        flags_reg <= flags_reg & ~pwdata[2:0];
      if (wd_fail) begin
        flags_reg[`ST_FLAG_WD] <= 1'b1;
        wd_fail_cnt_reg <= 1'b1;
        if (soft_cfg || wd_fail_cnt_reg)
          fail_outputs <= 1'b1;
      end
      if (apb_wr && addr_is(paddr, `STATUS_OFF) && pwdata[`ST_FLAG_OV] && !ov_event)
        core_overvolt_flag <= 1'b0;
      if (ov_event) begin
        core_overvolt_flag <= 1'b1;
        fail_outputs       <= 1'b1;
      end
      if (mode_reg == `MODE_NORMAL && timer_reg >= RESET_DELAY_CYCLES && !wd_fail)
        wd_fail_cnt_reg <= wd_fail_cnt_reg;
    end
  end

  // Mode outputs; mode bits read back as the live mode, with restart reading as init
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_supply_enable    <= 1'b1;
      core_supply_low_power <= 1'b0;
      watchdog_running      <= 1'b0;
      operating_mode_bits   <= `MODE_INIT;
    end else begin
      core_supply_enable    <= (mode_next != `MODE_SLEEP) & (mode_next != `MODE_FAILSAFE);
      core_supply_low_power <= (mode_next == `MODE_STOP);
      watchdog_running      <= wd_active & ~dev_next;
      operating_mode_bits   <= (mode_next == `MODE_RESTART) ? `MODE_INIT : mode_next;
    end
  end

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    if (addr_is(paddr, `MODE_CTRL_OFF))
      rd_mux = {29'h0, operating_mode_bits};
    else if (addr_is(paddr, `HARDWARE_CONTROL_REG_OFF))
      rd_mux = {30'h0, hardware_control_reg};
    else if (addr_is(paddr, `WAKE_LVL_OFF))
      rd_mux = {30'h0, development_mode, pin_strap_config};
    else if (addr_is(paddr, `STATUS_OFF))
      rd_mux = {28'h0, core_overvolt_flag, flags_reg[2], flags_reg[1] | core_overvolt_flag, flags_reg[0]};
    else if (addr_is(paddr, `FRAME_OFF))
      rd_mux = {16'h0, frame_reg};
  end

  // Captured in the setup cycle so the zero-wait access phase sees flip-flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (apb_setup_rd)
      prdata <= rd_mux;
  end

endmodule
`default_nettype wire

// >>> rtl/supply_mode_map.vh
// Constants for the operating-mode and failure-response block.
// Assumes a 50 MHz pclk and APB word-aligned register access.
//
// Overview of operation
// - Enter init mode at power-up and after a software reset.
// - Stop mode keeps core supply on; sleep mode turns it off.
// - Restart holds host reset, then goes normal after reset delay once failure clears.
// - Fail-safe keeps core supply off until wake or over-temperature clears.
// - Development mode stops watchdog; chosen by grounded test pin during init.
// - Configuration and diagnosis use 16-bit serial frames.
// - Mode bits set mode; cleared through restart so they show current mode.
// - After power-on start in init with watchdog long open window.
// - Pull interrupt pin low during reset delay, filter, latch at reset rise.
// - While power-on flag set, re-pull and re-latch on every reset low.
// - No stable pin level during sampling latches zero, meaning fail-safe.
// - Strap high: watchdog failure restarts; fail outputs after first or second failure.
// - Strap low: watchdog failure fail-safe; with soft bit zero first failure restarts.
// - Overvoltage reset enabled, strap high: restart, set flag, assert fail outputs.
// - Overvoltage reset enabled, strap low: fail-safe, set flag, assert fail outputs.
// - Host reads soft configuration bit and latched strap bit.
// - Latched strap holds in every mode once power-on flag is cleared, until power-on reset.
// - Any serial command in init moves to normal mode.
// - No watchdog trigger within long open window is a watchdog failure.
// - Wake events in init mode are discarded.
`ifndef SUPPLY_MODE_MAP_VH
`define SUPPLY_MODE_MAP_VH

`define MODE_CTRL_OFF     12'h000
`define HARDWARE_CONTROL_REG_OFF       12'h004
`define WAKE_LVL_OFF      12'h008
`define STATUS_OFF        12'h00c
`define FRAME_OFF         12'h010

`define MODE_W            3
`define MODE_INIT         3'h0
`define MODE_NORMAL       3'h1
`define MODE_STOP         3'h2
`define MODE_SLEEP        3'h3
`define MODE_RESTART      3'h4
`define MODE_FAILSAFE     3'h5

`define CTRL_SOFT_RESET   3'h6

`define HW_CFG_BIT        0
`define HW_OV_RST_BIT     1
`define HARDWARE_CONTROL_REG_RESET     2'h0

`define ST_FLAG_POR       0
`define ST_FLAG_OV        1
`define ST_FLAG_WD        2

`define RESET_DELAY_NS    10000
`define FILTER_NS         200
`define LONG_WINDOW_NS    200000000
`define CLK_PERIOD_NS     20
`define RESET_DELAY_CYC   ((`RESET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILTER_CYC        ((`FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_WINDOW_CYC   (`LONG_WINDOW_NS / `CLK_PERIOD_NS)

`endif

// >>> tb/board_strap_model.sv
// Board side of the interrupt pin: optional pull-up, or a noisy line.
// Assumes the fitted pull-up overrides the weak internal pull-down.
`timescale 1ns/1ps
`default_nettype none
module board_strap_model (
  input  wire logic clk,
  input  wire logic pull_up_fit,
  input  wire logic noisy,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level
);
  logic toggle_reg = 1'h0;
  always_ff @(posedge clk) toggle_reg <= !toggle_reg;
  // Undriven and unpulled, the line wanders rather than holding a value
  assign pin_level = noisy ? toggle_reg : pull_up_fit ? 1'h1 : pin_oe ? pin_out : toggle_reg;
endmodule
`default_nettype wire

// >>> tb/supply_mode_checker_properties.sv
// Concurrent checks on the operating-mode block's top-level ports.
// Assumes one pclk domain and asynchronous active-low presetn.
`timescale 1ns/1ps
`default_nettype none
`include "supply_mode_map.vh"
module supply_mode_checker #(
  parameter [31:0] RESET_DELAY_CYCLES = 32'h14
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        wake_event,
  input wire logic        overtemp,
  input wire logic        int_pin_out,
  input wire logic        int_pin_oe,
  input wire logic        host_reset_output,
  input wire logic        fail_outputs,
  input wire logic        core_supply_enable,
  input wire logic        core_supply_low_power,
  input wire logic        watchdog_running,
  input wire logic        development_mode,
  input wire logic [2:0]  operating_mode_bits
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] low_cnt_reg;
  // Counts host-reset low time so the delay can be judged on release
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_cnt_reg <= 32'h0;
    else
      low_cnt_reg <= host_reset_output ? 32'h0 : low_cnt_reg + 32'h1;
  sequence s_in_init; operating_mode_bits == `MODE_INIT && host_reset_output; endsequence
  sequence s_frame_wr; psel && penable && pwrite && paddr == `FRAME_OFF; endsequence
  property p_init; $rose(presetn) |-> operating_mode_bits == `MODE_INIT && !host_reset_output; endproperty
  a_init: assert property (p_init) else $error("no init entry");
  property p_stop; (operating_mode_bits == `MODE_STOP)[*2] |-> core_supply_enable && core_supply_low_power; endproperty
  a_stop: assert property (p_stop) else $error("stop supply wrong");
  property p_sleep; (operating_mode_bits == `MODE_SLEEP)[*2] |-> !core_supply_enable; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep supply on");
  property p_hold; $fell(host_reset_output) |=> (!host_reset_output)[*8]; endproperty
  a_hold: assert property (p_hold) else $error("host reset too short");
  property p_delay; $rose(host_reset_output) |-> low_cnt_reg >= RESET_DELAY_CYCLES - 32'h2; endproperty
  a_delay: assert property (p_delay) else $error("reset delay short");
  property p_safe; (!core_supply_enable && overtemp && !wake_event)[*3] |=> !core_supply_enable; endproperty
  a_safe: assert property (p_safe) else $error("fail-safe left early");
  property p_dev; development_mode |-> !watchdog_running; endproperty
  a_dev: assert property (p_dev) else $error("watchdog runs in dev");
  property p_pull; int_pin_oe |-> !host_reset_output && !int_pin_out; endproperty
  a_pull: assert property (p_pull) else $error("pull-down outside delay");
  property p_fail; $rose(fail_outputs) |=> fail_outputs[*8]; endproperty
  a_fail: assert property (p_fail) else $error("fail outputs dropped");
  property p_frame; s_in_init ##0 s_frame_wr |=> ##[0:2] operating_mode_bits == `MODE_NORMAL; endproperty
  a_frame: assert property (p_frame) else $error("frame kept init");
endmodule
`default_nettype wire

// >>> tb/supply_mode_fail_config_tb_top.sv
// Self-checking bench for supply_mode_fail_config with a board strap model.
// Assumes short reset-delay and window parameters to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
`include "supply_mode_map.vh"
module supply_mode_fail_config_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        int_pin_in, int_pin_out, int_pin_oe, test_pin, wake_event, overtemp;
  logic        core_overvolt, host_reset_output, fail_outputs, core_supply_enable;
  logic        core_supply_low_power, watchdog_running, development_mode, pull_up_fit, noisy;
  logic [2:0]  operating_mode_bits;
  int          err_total, n_compared, cyc;
  supply_mode_fail_config #(.RESET_DELAY_CYCLES(32'h14), .LONG_WINDOW_CYCLES(32'hc8))
    u_supply_mode_fail_config (.*, .core_undervolt(1'h0), .wd_trigger(1'h0));
  board_strap_model u_board_strap_model (.clk(pclk), .pull_up_fit(pull_up_fit), .noisy(noisy),
    .pin_out(int_pin_out), .pin_oe(int_pin_oe), .pin_level(int_pin_in));
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, e, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, q & m, e);
  endtask
  // Waits at falling edges so that outputs have settled
  task automatic wt(input logic core, lvl, input string nm);
    int i;
    for (i = 0; i < 2000 && (core ? core_supply_enable : host_reset_output) !== lvl; i++)
      @(negedge pclk);
    chk(nm, core ? core_supply_enable : host_reset_output, lvl);
  endtask
  task automatic power_up(input logic pu, nz, tp);
    @(posedge pclk);
    presetn     <= 1'h0;
    pull_up_fit <= pu;
    noisy       <= nz;
    test_pin    <= tp;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    wt(1'h0, 1'h1, "host reset release");
  endtask
  task automatic t_strap_high;
    power_up(1'h1, 1'h0, 1'h1);
    rd(`MODE_CTRL_OFF, 32'h7, 32'h0, "mode init");
    rd(`WAKE_LVL_OFF, 32'h3, 32'h1, "strap high");
    apb(1'h1, `FRAME_OFF, 32'h1234);
    rd(`MODE_CTRL_OFF, 32'h7, 32'h1, "mode normal");
    apb(1'h1, `HARDWARE_CONTROL_REG_OFF, 32'h3);
    core_overvolt <= 1'h1;
    wt(1'h0, 1'h0, "ov restart");
    chk("ov fail outputs", fail_outputs, 1'h1);
    rd(`STATUS_OFF, 32'h2, 32'h2, "ov flag");
    core_overvolt <= 1'h0;
    wt(1'h0, 1'h1, "restart exit");
    rd(`MODE_CTRL_OFF, 32'h7, 32'h1, "mode after restart");
    apb(1'h1, `STATUS_OFF, 32'h1);
    pull_up_fit <= 1'h0;
    apb(1'h1, `HARDWARE_CONTROL_REG_OFF, 32'h1);
    wt(1'h0, 1'h0, "wd restart");
    rd(`MODE_CTRL_OFF, 32'h7, 32'h0, "restart mode bits");
    wt(1'h0, 1'h1, "wd restart exit");
    rd(`WAKE_LVL_OFF, 32'h1, 32'h1, "strap kept");
    rd(`STATUS_OFF, 32'h5, 32'h4, "wd flag");
    rd(`HARDWARE_CONTROL_REG_OFF, 32'h3, 32'h1, "soft cfg");
    apb(1'h1, `MODE_CTRL_OFF, 32'h2);
    rd(`MODE_CTRL_OFF, 32'h7, 32'h2, "stop mode");
    chk("stop low power", core_supply_low_power, 1'h1);
    apb(1'h1, `MODE_CTRL_OFF, 32'h1);
    apb(1'h1, `MODE_CTRL_OFF, 32'h3);
    wt(1'h1, 1'h0, "sleep supply off");
    @(posedge pclk);
    wake_event <= 1'h1;
    wt(1'h1, 1'h1, "wake supply on");
    @(posedge pclk);
    wake_event <= 1'h0;
    wt(1'h0, 1'h1, "wake restart exit");
    apb(1'h1, `MODE_CTRL_OFF, 32'h6);
    rd(`MODE_CTRL_OFF, 32'h7, 32'h0, "soft reset init");
    $display("strap high test done");
  endtask
  task automatic t_strap_low;
    power_up(1'h0, 1'h0, 1'h1);
    rd(`WAKE_LVL_OFF, 32'h1, 32'h0, "strap low");
    apb(1'h1, `FRAME_OFF, 32'h0);
    overtemp <= 1'h1;
    wt(1'h0, 1'h0, "first wd fail");
    chk("first fail outputs", fail_outputs, 1'h0);
    wt(1'h0, 1'h1, "first restart exit");
    wt(1'h1, 1'h0, "fail-safe entry");
    chk("second fail outputs", fail_outputs, 1'h1);
    repeat (30) @(negedge pclk);
    chk("fail-safe hold", core_supply_enable, 1'h0);
    @(posedge pclk);
    overtemp <= 1'h0;
    wt(1'h1, 1'h1, "fail-safe exit");
    $display("strap low test done");
  endtask
  task automatic t_dev;
    power_up(1'h1, 1'h1, 1'h0);
    rd(`WAKE_LVL_OFF, 32'h3, 32'h2, "noisy strap dev");
    chk("dev mode", development_mode, 1'h1);
    chk("wd stopped", watchdog_running, 1'h0);
    $display("dev test done");
  endtask
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    {test_pin, wake_event, overtemp, core_overvolt, pull_up_fit, noisy} = 6'h20;
    t_strap_high();
    t_strap_low();
    t_dev();
    stop_test();
  end
endmodule
bind supply_mode_fail_config supply_mode_checker #(.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)) u_supply_mode_checker (.*);
`default_nettype wire
